// >>> verilog/bsfs_pkg.sv
`default_nettype none
package bsfs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Flash opcodes, one fixed set for every attached part
  localparam logic [7:0] OP_FAST_READ     = 8'h0B;
  localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE    = 8'hC7;
  localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] STATUS_CLEAR     = 8'h00;
  localparam logic [7:0] DUMMY_BYTE       = 8'h00;

  // Status byte fields
  localparam int FLASH_BUSY_FLAG  = 0;
  localparam int WRITE_LATCH_BIT  = 1;
  localparam int STATUS_LOCK_FLAG = 7;

  localparam int PAGE_BYTES   = 256;
  localparam int SECTOR_BYTES = 4096;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock rates, derived from the link clock (6 ns)
  localparam int LINK_CLK_KHZ = 166667;
  localparam int SLOW_SCK_KHZ = 1420;
  localparam int FAST_SCK_KHZ = 30000;
  // Half periods round up so the serial clock never exceeds its nominal rate
  localparam logic [7:0] SLOW_HALF =
    8'((LINK_CLK_KHZ + 2 * SLOW_SCK_KHZ - 1) / (2 * SLOW_SCK_KHZ));
  localparam logic [7:0] FAST_HALF =
    8'((LINK_CLK_KHZ + 2 * FAST_SCK_KHZ - 1) / (2 * FAST_SCK_KHZ));

  localparam logic [23:0] BOOT_ADDR = 24'h000000;
  localparam logic [23:0] BOOT_LEN_DEFAULT = 24'h010000;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    CMD_READ    = 2'h0,
    CMD_PROGRAM = 2'h1,
    CMD_SECTOR  = 2'h2,
    CMD_CHIP    = 2'h3
  } bsfs_op_e;

  typedef enum logic [5:0] {
    S_IDLE         = 6'h01,
    S_UNLOCK       = 6'h02,
    S_LATCH_POLL   = 6'h04,
    S_STATUS_CLEAR = 6'h08,
    S_CMD          = 6'h10,
    S_BUSY_POLL    = 6'h20
  } bsfs_seq_state_e;

  typedef enum logic [2:0] {
    E_IDLE = 3'h1,
    E_LOW  = 3'h2,
    E_HIGH = 3'h4
  } bsfs_eng_state_e;

endpackage
`default_nettype wire

// >>> verilog/bsfs_link_if.sv
`default_nettype none
// Byte requests cross by toggle: data is held stable while a toggle is in flight
interface bsfs_link_if;
  logic       req_tgl;
  logic [7:0] tx_byte;
  logic       last_byte;
  logic       fast_clk;
  logic       ack_tgl;
  logic [7:0] rx_byte;

  modport seq (output req_tgl, output tx_byte, output last_byte, output fast_clk,
               input ack_tgl, input rx_byte);
  modport eng (input req_tgl, input tx_byte, input last_byte, input fast_clk,
               output ack_tgl, output rx_byte);
endinterface
`default_nettype wire

// >>> verilog/bsfs_spi_engine.sv
`default_nettype none
module bsfs_spi_engine (
  input  wire logic link_clk_in,
  input  wire logic reset_in,
  bsfs_link_if.eng  link,
  input  wire logic spi_miso_in,
  output logic      spi_clk_out,
  output logic      spi_mosi_out,
  output logic      boot_flash_select_n_out
);
  import bsfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release is resynchronised to the link clock
  logic [1:0] rst_sync;
  logic       link_rst;
  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rst_sync <= 2'h3;
    end else begin
      rst_sync <= {rst_sync[0], 1'b0};
    end
  end
  assign link_rst = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  bsfs_eng_state_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [2:0] bit_idx, next_bit_idx;
  logic [7:0] shift_tx, next_shift_tx;
  logic [7:0] shift_rx, next_shift_rx;
  logic [7:0] rx_byte, next_rx_byte;
  logic       sck, next_sck;
  logic       cs_n, next_cs_n;
  logic       last, next_last;
  logic       fast, next_fast;
  logic       ack, next_ack;
  logic       req_meta, req_sync, req_seen, next_req_seen;
  logic       miso_meta, miso_sync;
  logic [7:0] half;

  assign half = fast ? FAST_HALF : SLOW_HALF;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_bit_idx  = bit_idx;
    next_shift_tx = shift_tx;
    next_shift_rx = shift_rx;
    next_rx_byte  = rx_byte;
    next_sck      = sck;
    next_cs_n     = cs_n;
    next_last     = last;
    next_fast     = fast;
    next_ack      = ack;
    next_req_seen = req_seen;
    case (state)
      E_IDLE: begin
        if (req_sync != req_seen) begin
          next_req_seen = req_sync;
          next_cs_n     = 1'b0;
          next_shift_tx = link.tx_byte;
          next_last     = link.last_byte;
          next_fast     = link.fast_clk;
          next_bit_idx  = 3'h7;
          next_cnt      = link.fast_clk ? FAST_HALF : SLOW_HALF;
          next_state    = E_LOW;
        end
      end
      E_LOW: begin
        if (cnt == 8'h01) begin
          next_sck   = 1'b1;
          next_cnt   = half;
          next_state = E_HIGH;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      E_HIGH: begin
        if (cnt == 8'h01) begin
          // Sampled late in the high phase: the synchroniser delay stays inside it
          next_sck      = 1'b0;
          next_shift_rx = {shift_rx[6:0], miso_sync};
          if (bit_idx == 3'h0) begin
            next_rx_byte = {shift_rx[6:0], miso_sync};
            next_ack     = ~ack;
            next_cs_n    = last;
            next_state   = E_IDLE;
          end else begin
            next_bit_idx  = bit_idx - 3'h1;
            next_shift_tx = {shift_tx[6:0], 1'b0};
            next_cnt      = half;
            next_state    = E_LOW;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        next_state = E_IDLE;
        next_cs_n  = 1'b1;
        next_sck   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or posedge link_rst) begin
    if (link_rst) begin
      state     <= E_IDLE;
      cnt       <= 8'h00;
      bit_idx   <= 3'h0;
      shift_tx  <= 8'h00;
      shift_rx  <= 8'h00;
      rx_byte   <= 8'h00;
      sck       <= 1'b0;
      cs_n      <= 1'b1;
      last      <= 1'b0;
      fast      <= 1'b0;
      ack       <= 1'b0;
      req_meta  <= 1'b0;
      req_sync  <= 1'b0;
      req_seen  <= 1'b0;
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      bit_idx   <= next_bit_idx;
      shift_tx  <= next_shift_tx;
      shift_rx  <= next_shift_rx;
      rx_byte   <= next_rx_byte;
      sck       <= next_sck;
      cs_n      <= next_cs_n;
      last      <= next_last;
      fast      <= next_fast;
      ack       <= next_ack;
      req_meta  <= link.req_tgl;
      req_sync  <= req_meta;
      req_seen  <= next_req_seen;
      miso_meta <= spi_miso_in;
      miso_sync <= miso_meta;
    end
  end

  assign spi_clk_out             = sck;
  assign spi_mosi_out            = shift_tx[7];
  assign boot_flash_select_n_out = cs_n;
  assign link.ack_tgl            = ack;
  assign link.rx_byte            = rx_byte;

  ////////////////////////////////////////////////////////////////////////////////
  property p_select_held;
    @(posedge link_clk_in) disable iff (link_rst)
      (state != E_IDLE) |-> !boot_flash_select_n_out;
  endproperty
  a_select_held: assert property (p_select_held) else $error("select high mid byte");

  property p_clock_idle_low;
    @(posedge link_clk_in) disable iff (link_rst)
      (state == E_IDLE) |-> !spi_clk_out;
  endproperty
  a_clock_idle_low: assert property (p_clock_idle_low) else $error("clock idles high");

  property p_data_stable_high;
    @(posedge link_clk_in) disable iff (link_rst)
      spi_clk_out |-> $stable(spi_mosi_out);
  endproperty
  a_data_stable_high: assert property (p_data_stable_high) else $error("data moved");

  property p_fast_high_phase;
    @(posedge link_clk_in) disable iff (link_rst)
      ($rose(spi_clk_out) && fast) |-> spi_clk_out[*3] ##1 !spi_clk_out;
  endproperty
  a_fast_high_phase: assert property (p_fast_high_phase) else $error("fast phase length");

endmodule
`default_nettype wire

// >>> verilog/bsfs_flash_seq.sv
`default_nettype none
module bsfs_flash_seq #(
  parameter logic [23:0] BOOT_LEN = bsfs_pkg::BOOT_LEN_DEFAULT
) (
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  input  wire logic               link_clk_in,
  output logic                    spi_clk_out,
  output logic                    spi_mosi_out,
  output logic                    boot_flash_select_n_out,
  input  wire logic               spi_miso_in,
  input  wire logic               cmd_valid_in,
  output logic                    cmd_ready_out,
  input  wire bsfs_pkg::bsfs_op_e cmd_op_in,
  input  wire logic [23:0]        cmd_addr_in,
  input  wire logic [23:0]        cmd_len_in,
  input  wire logic [7:0]         wr_data_in,
  input  wire logic               wr_valid_in,
  output logic                    wr_ready_out,
  output logic [7:0]              rd_data_out,
  output logic                    rd_valid_out,
  input  wire logic               rd_ready_in,
  output logic                    boot_active_out,
  output logic                    boot_done_out,
  output logic [7:0]              flash_status_out,
  output logic                    high_speed_out
);
  import bsfs_pkg::*;

  bsfs_link_if link ();

  bsfs_spi_engine u_engine (
    .link_clk_in             (link_clk_in),
    .reset_in                (reset_in),
    .link                    (link.eng),
    .spi_miso_in             (spi_miso_in),
    .spi_clk_out             (spi_clk_out),
    .spi_mosi_out            (spi_mosi_out),
    .boot_flash_select_n_out (boot_flash_select_n_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  bsfs_seq_state_e state, next_state;
  bsfs_op_e    cur_op, next_cur_op;
  logic [23:0] cur_addr, next_cur_addr;
  logic [23:0] remain, next_remain;
  logic [2:0]  idx, next_idx;
  logic        booting, next_booting;
  logic        boot_done, next_boot_done;
  logic        fast, next_fast;
  logic        pend, next_pend;
  logic        req, next_req;
  logic [7:0]  tx, next_tx;
  logic        last, next_last;
  logic [7:0]  status, next_status;
  logic        ack_meta, ack_sync, ack_seen;
  logic        ack_done;
  logic [7:0]  plan_tx;
  logic        plan_last;
  logic        plan_go;
  logic        issue;
  logic        push;
  logic        pop;
  logic [7:0]  mem [2];
  logic [7:0]  next_mem [2];
  logic        wr_ptr, next_wr_ptr;
  logic        rd_ptr, next_rd_ptr;
  logic [1:0]  count, next_count;
  logic        buf_room;

  assign ack_done = (ack_sync != ack_seen);
  assign buf_room = (count != 2'h2);

  ////////////////////////////////////////////////////////////////////////////////
  // Byte plan for the current step of the current command
  always_comb begin
    plan_tx   = DUMMY_BYTE;
    plan_last = 1'b0;
    plan_go   = 1'b0;
    case (state)
      S_UNLOCK: begin
        plan_tx   = OP_WRITE_UNLOCK;
        plan_last = 1'b1;
        plan_go   = 1'b1;
      end
      S_LATCH_POLL, S_BUSY_POLL: begin
        plan_tx   = (idx == 3'h0) ? OP_STATUS_READ : DUMMY_BYTE;
        plan_last = (idx != 3'h0);
        plan_go   = 1'b1;
      end
      S_STATUS_CLEAR: begin
        plan_tx   = (idx == 3'h0) ? OP_STATUS_WRITE : STATUS_CLEAR;
        plan_last = (idx != 3'h0);
        plan_go   = 1'b1;
      end
      S_CMD: begin
        plan_go = 1'b1;
        case (idx)
          3'h0: begin
            case (cur_op)
              CMD_READ:    plan_tx = OP_FAST_READ;
              CMD_PROGRAM: plan_tx = OP_PAGE_PROG;
              CMD_SECTOR:  plan_tx = OP_SECTOR_ERASE;
              default:     plan_tx = OP_CHIP_ERASE;
            endcase
            plan_last = (cur_op == CMD_CHIP);
          end
          3'h1: plan_tx = cur_addr[23:16];
          3'h2: plan_tx = cur_addr[15:8];
          3'h3: begin
            plan_tx   = cur_addr[7:0];
            plan_last = (cur_op == CMD_SECTOR);
          end
          3'h4: begin
            if (cur_op == CMD_PROGRAM) begin
              plan_tx   = wr_data_in;
              plan_last = (remain == 24'h000001);
              plan_go   = wr_valid_in;
            end
          end
          default: begin
            // Stalls while the output buffer is full so no read byte is lost
            plan_last = (remain == 24'h000001);
            plan_go   = buf_room;
          end
        endcase
      end
      default: plan_go = 1'b0;
    endcase
  end

  assign issue = !pend && plan_go;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state     = state;
    next_cur_op    = cur_op;
    next_cur_addr  = cur_addr;
    next_remain    = remain;
    next_idx       = idx;
    next_booting   = booting;
    next_boot_done = boot_done;
    next_fast      = fast;
    next_pend      = pend;
    next_req       = req;
    next_tx        = tx;
    next_last      = last;
    next_status    = status;
    push           = 1'b0;
    if (issue) begin
      next_pend = 1'b1;
      next_req  = ~req;
      next_tx   = plan_tx;
      next_last = plan_last;
    end
    if (ack_done) begin
      next_pend = 1'b0;
    end
    case (state)
      S_IDLE: begin
        if (cmd_valid_in) begin
          next_cur_op   = cmd_op_in;
          next_cur_addr = cmd_addr_in;
          next_remain   = (cmd_len_in == 24'h000000) ? 24'h000001 : cmd_len_in;
          next_idx      = 3'h0;
          next_state    = (cmd_op_in == CMD_READ) ? S_CMD : S_UNLOCK;
        end
      end
      S_UNLOCK: begin
        if (ack_done) begin
          next_idx   = 3'h0;
          next_state = S_LATCH_POLL;
        end
      end
      S_LATCH_POLL: begin
        if (ack_done) begin
          if (idx == 3'h0) begin
            next_idx = 3'h1;
          end else begin
            next_idx    = 3'h0;
            next_status = link.rx_byte;
            // The latch clears after every program or erase, so it is always re-polled
            if (link.rx_byte[WRITE_LATCH_BIT]) begin
              next_state = booting ? S_STATUS_CLEAR : S_CMD;
            end
          end
        end
      end
      S_STATUS_CLEAR: begin
        if (ack_done) begin
          next_idx   = (idx == 3'h0) ? 3'h1 : 3'h0;
          next_state = (idx == 3'h0) ? S_STATUS_CLEAR : S_BUSY_POLL;
        end
      end
      S_BUSY_POLL: begin
        if (ack_done) begin
          if (idx == 3'h0) begin
            next_idx = 3'h1;
          end else begin
            next_idx    = 3'h0;
            next_status = link.rx_byte;
            if (!link.rx_byte[FLASH_BUSY_FLAG]) begin
              if (booting) begin
                next_cur_op   = CMD_READ;
                next_cur_addr = BOOT_ADDR;
                next_remain   = BOOT_LEN;
                next_fast     = 1'b1;
                next_state    = S_CMD;
              end else begin
                next_state = S_IDLE;
              end
            end
          end
        end
      end
      S_CMD: begin
        if (ack_done) begin
          if (idx == 3'h5) begin
            push        = 1'b1;
            next_remain = remain - 24'h000001;
          end else if (idx == 3'h4 && cur_op == CMD_PROGRAM) begin
            next_remain = remain - 24'h000001;
          end else begin
            next_idx = idx + 3'h1;
          end
          if (last) begin
            next_idx = 3'h0;
            if (cur_op == CMD_READ) begin
              next_state = S_IDLE;
              if (booting) begin
                next_booting   = 1'b0;
                next_boot_done = 1'b1;
              end
            end else begin
              next_state = S_BUSY_POLL;
            end
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer
  assign pop = (count != 2'h0) && rd_ready_in;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_mem[i] = mem[i];
    end
    if (push) begin
      next_mem[wr_ptr] = link.rx_byte;
    end
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state     <= S_UNLOCK;
      cur_op    <= CMD_READ;
      cur_addr  <= 24'h000000;
      remain    <= 24'h000000;
      idx       <= 3'h0;
      booting   <= 1'b1;
      boot_done <= 1'b0;
      fast      <= 1'b0;
      pend      <= 1'b0;
      req       <= 1'b0;
      tx        <= 8'h00;
      last      <= 1'b0;
      status    <= 8'h00;
      ack_meta  <= 1'b0;
      ack_sync  <= 1'b0;
      ack_seen  <= 1'b0;
      mem[0]    <= 8'h00;
      mem[1]    <= 8'h00;
      wr_ptr    <= 1'b0;
      rd_ptr    <= 1'b0;
      count     <= 2'h0;
    end else begin
      state     <= next_state;
      cur_op    <= next_cur_op;
      cur_addr  <= next_cur_addr;
      remain    <= next_remain;
      idx       <= next_idx;
      booting   <= next_booting;
      boot_done <= next_boot_done;
      fast      <= next_fast;
      pend      <= next_pend;
      req       <= next_req;
      tx        <= next_tx;
      last      <= next_last;
      status    <= next_status;
      ack_meta  <= link.ack_tgl;
      ack_sync  <= ack_meta;
      ack_seen  <= ack_sync;
      mem       <= next_mem;
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
    end
  end

  assign link.req_tgl     = req;
  assign link.tx_byte     = tx;
  assign link.last_byte   = last;
  assign link.fast_clk    = fast;
  assign cmd_ready_out    = (state == S_IDLE);
  assign wr_ready_out     = issue && (state == S_CMD) && (idx == 3'h4)
                            && (cur_op == CMD_PROGRAM);
  assign rd_data_out      = mem[rd_ptr];
  assign rd_valid_out     = (count != 2'h0);
  assign boot_active_out  = booting;
  assign boot_done_out    = boot_done;
  assign flash_status_out = status;
  assign high_speed_out   = fast;

  ////////////////////////////////////////////////////////////////////////////////
  property p_latch_before_write;
    @(posedge clk_in) disable iff (reset_in)
      (issue && state == S_CMD && idx == 3'h0 && cur_op != CMD_READ)
        |-> status[WRITE_LATCH_BIT] && $past(state) == S_LATCH_POLL;
  endproperty
  a_latch_before_write: assert property (p_latch_before_write) else $error("no latch");

  property p_erase_shape;
    @(posedge clk_in) disable iff (reset_in)
      (issue && state == S_CMD && idx == 3'h3) |-> (plan_last == (cur_op == CMD_SECTOR));
  endproperty
  a_erase_shape: assert property (p_erase_shape) else $error("erase length wrong");

  property p_boot_unlock_first;
    @(posedge clk_in) disable iff (reset_in)
      (booting && state == S_UNLOCK && issue) |-> plan_tx == OP_WRITE_UNLOCK ##1 pend;
  endproperty
  a_boot_unlock_first: assert property (p_boot_unlock_first) else $error("boot unlock");

  property p_status_clear;
    @(posedge clk_in) disable iff (reset_in)
      (issue && state == S_STATUS_CLEAR && idx == 3'h1)
        |-> plan_tx == STATUS_CLEAR && plan_last && status[WRITE_LATCH_BIT];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status clear wrong");

  property p_one_status_byte;
    @(posedge clk_in) disable iff (reset_in)
      (issue && idx == 3'h1 && (state == S_LATCH_POLL || state == S_BUSY_POLL))
        |-> plan_last;
  endproperty
  a_one_status_byte: assert property (p_one_status_byte) else $error("extra status");

  property p_busy_clear_first;
    @(posedge clk_in) disable iff (reset_in)
      (state == S_IDLE && $past(state) == S_BUSY_POLL) |-> !status[FLASH_BUSY_FLAG];
  endproperty
  a_busy_clear_first: assert property (p_busy_clear_first) else $error("left busy");

  property p_slow_before_load;
    @(posedge clk_in) disable iff (reset_in)
      (issue && booting && state != S_CMD) |-> !fast;
  endproperty
  a_slow_before_load: assert property (p_slow_before_load) else $error("fast too early");

  property p_read_dummy;
    @(posedge clk_in) disable iff (reset_in)
      (issue && state == S_CMD && idx == 3'h4 && cur_op == CMD_READ)
        |-> plan_tx == DUMMY_BYTE && !plan_last;
  endproperty
  a_read_dummy: assert property (p_read_dummy) else $error("dummy byte wrong");

  property p_boot_source;
    @(posedge clk_in) disable iff (reset_in)
      (state == S_CMD && booting) |-> cur_op == CMD_READ && cur_addr == BOOT_ADDR;
  endproperty
  a_boot_source: assert property (p_boot_source) else $error("boot read wrong");

endmodule
`default_nettype wire

// >>> verilog/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// >>> verif/bsfs_flash_model.sv
`default_nettype none
module bsfs_flash_model (
  input  wire logic sck_in,
  input  wire logic mosi_in,
  input  wire logic sel_n_in,
  output logic      miso_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Starts locked so the boot unlock has something to undo
  logic [7:0]  sr  = 8'h9C;
  logic [7:0]  rx  = '0, tx = '0, nxt = '0, op = '0;
  logic [47:0] sig = '0;
  logic [23:0] addr = '0;
  int          bits, idx, busy_n, n_prog;
  logic [23:0] pdat = '0;
  bit          lag_pend, first_unlock = 1'b1;
  realtime     t_up, per_min = 1.0e6, per_max = 0.0;
  always @(negedge sel_n_in) begin
    bits = 0;
    idx = 0;
  end
  always @(posedge sck_in) begin
    // Bit-to-bit spacing only: the gap between bytes may stretch while reads stall
    if (bits != 0 && $realtime - t_up < per_min) per_min = $realtime - t_up;
    if (bits != 0 && $realtime - t_up > per_max) per_max = $realtime - t_up;
    t_up = $realtime;
    rx = {rx[6:0], mosi_in};
    bits++;
    if (bits == 8) begin
      bits = 0;
      if (idx == 0) begin
        op = rx;
        sig = {sig[39:0], rx};
      end else if (idx < 4) addr = {addr[15:0], rx};
      if (op == 8'h01 && idx == 1) sr = rx;
      if (op == 8'h02 && idx > 3) begin
        n_prog++;
        pdat = {pdat[15:0], rx};
      end
      nxt = (op == 8'h05) ? sr : 8'(addr + idx - 4);
      idx++;
    end
  end
  always @(posedge sel_n_in) begin
    // The first unlock latches one status read late, so the boot poll must repeat
    if (op == 8'h05 && lag_pend) begin
      sr[1] = 1'b1;
      lag_pend = 1'b0;
    end
    if (op == 8'h06) begin
      sr[1] = !first_unlock;
      lag_pend = first_unlock;
      first_unlock = 1'b0;
    end
    if (op inside {8'h02, 8'h20, 8'hC7}) begin
      sr[1:0] = 2'b01;
      busy_n = 2;
    end
    if (op == 8'h05 && busy_n > 0) begin
      busy_n--;
      sr[0] = busy_n > 0;
    end
    op = 8'h00;
  end
  always @(negedge sck_in) tx = (bits == 0) ? nxt : {tx[6:0], ~tx[0]};
  // Released line shows the inverse so a stale bit is never read as data
  assign miso_out = sel_n_in ? ~tx[7] : tx[7];
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bsfs_pkg::*;
  logic            clk_in = 0, link_clk_in = 0, reset_in = 1;
  logic            cmd_valid_in = 0, wr_valid_in = 0, rd_ready_in = 0;
  bsfs_op_e        cmd_op_in = CMD_READ;
  logic [23:0]     cmd_addr_in = '0, cmd_len_in = '0;
  logic [7:0]      wr_data_in = '0;
  wire logic       sck, mosi, sel_n, miso, c_rdy, w_rdy, r_vld, b_act, b_done, fast;
  wire logic [7:0] rd_data, status;
  int              n_mismatch, total_checks;
  always #10 clk_in = ~clk_in;
  initial #1.3 forever #3 link_clk_in = ~link_clk_in;
  bsfs_flash_seq #(.BOOT_LEN(24'h000006)) u_bsfs_flash_seq (.clk_in(clk_in),
    .reset_in(reset_in), .link_clk_in(link_clk_in), .spi_clk_out(sck), .spi_mosi_out(mosi),
    .boot_flash_select_n_out(sel_n), .spi_miso_in(miso), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(c_rdy), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in),
    .cmd_len_in(cmd_len_in), .wr_data_in(wr_data_in), .wr_valid_in(wr_valid_in),
    .wr_ready_out(w_rdy), .rd_data_out(rd_data), .rd_valid_out(r_vld),
    .rd_ready_in(rd_ready_in), .boot_active_out(b_act), .boot_done_out(b_done),
    .flash_status_out(status), .high_speed_out(fast));
  bsfs_flash_model u_bsfs_flash_model (.sck_in(sck), .mosi_in(mosi), .sel_n_in(sel_n),
    .miso_out(miso));
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_on(input int w);
    int n = 0;
    do begin
      @(negedge clk_in);
      if (++n > 20000) begin
        n_mismatch++;
        tally_and_finish();
      end
    end while ((w == 0 ? c_rdy : w == 1 ? r_vld : w_rdy) !== 1'b1);
  endtask
  task automatic get(input logic [7:0] exp);
    wait_on(1);
    chk("read byte", exp, rd_data);
    @(posedge clk_in) rd_ready_in <= 1'b1;
    @(posedge clk_in) rd_ready_in <= 1'b0;
  endtask
  task automatic issue(input bsfs_op_e op, input logic [23:0] a, input logic [23:0] n);
    wait_on(0);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_op_in <= op;
    cmd_addr_in <= a;
    cmd_len_in <= n;
    @(posedge clk_in) cmd_valid_in <= 1'b0;
  endtask
  // Boot copy with a stalled consumer: the full buffer must hold the link
  task automatic boot_scn;
    wait_on(1);
    repeat (100) @(negedge clk_in);
    for (int i = 0; i < 6; i++) get(8'(i));
    wait_on(0);
    chk("boot order", 48'h06050501050B, u_bsfs_flash_model.sig);
    chk("protect bits", 6'h00, u_bsfs_flash_model.sr[7:2]);
    chk("boot flags", 3'h6, {b_done, fast, b_act});
    chk("clock range", 1'b1, u_bsfs_flash_model.per_min > 1000.0 / 30.1
        && u_bsfs_flash_model.per_max < 1000.0 / 1.4);
  endtask
  task automatic prog_scn;
    @(posedge clk_in);
    wr_valid_in <= 1'b1;
    wr_data_in <= 8'hA0;
    issue(CMD_PROGRAM, 24'h000120, 24'h000003);
    for (int i = 1; i <= 3; i++) begin
      wait_on(2);
      @(posedge clk_in) wr_data_in <= 8'(8'hA0 + i);
    end
    wr_valid_in <= 1'b0;
    wait_on(0);
    chk("program order", 48'h060502050505, u_bsfs_flash_model.sig);
    chk("program bytes", 48'h3, u_bsfs_flash_model.n_prog);
    chk("program data", 48'hA0A1A2, u_bsfs_flash_model.pdat);
    chk("status seen", 2'h0, status[1:0]);
  endtask
  task automatic erase_scn;
    issue(CMD_SECTOR, 24'h001000, 24'h000000);
    wait_on(0);
    chk("sector order", 48'h060520050505, u_bsfs_flash_model.sig);
    issue(CMD_CHIP, 24'h000000, 24'h000000);
    wait_on(0);
    chk("chip order", 48'h0605C7050505, u_bsfs_flash_model.sig);
  endtask
  task automatic read_scn;
    issue(CMD_READ, 24'h0000FE, 24'h000004);
    wait_on(1);
    repeat (50) @(negedge clk_in);
    for (int i = 0; i < 4; i++) get(8'(8'hFE + i));
    wait_on(0);
    chk("read op", 8'h0B, u_bsfs_flash_model.sig[7:0]);
    issue(CMD_READ, 24'h000010, 24'h000000);
    get(8'h10);
    wait_on(0);
    chk("zero length", 1'b0, r_vld);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset outputs", 3'h5, {sel_n, c_rdy, b_act});
    @(posedge clk_in) reset_in <= 1'b0;
    boot_scn();
    prog_scn();
    erase_scn();
    read_scn();
    tally_and_finish();
  end
endmodule
`default_nettype wire
